// [bru_byte_rotate_unit.sv]
// byte rotate unit: single-position rotates of a memory operand
// results land one cycle after the taking edge; write-back is a strobe to memory
// assumes operand, op and start are synchronous to clk and valid together
// assumes the memory side applies a write on the edge after mem_we_ff rises
// assumes resetn may fall at any time; its release is retimed inside
`timescale 1ns/1ps
module bru_byte_rotate_unit
   import bru_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic start,
   input wire bru_op_type op,
   input wire logic [7:0] mem_operand,
   output logic [7:0] work_reg_ff,
   output logic carry_ff,
   output logic [7:0] mem_wdata_ff,
   output logic mem_we_ff,
   output logic done_ff
);
   // ==========================================================
   // reset release
   logic rst_meta_ff;
   logic rst_n_ff;

   // two-stage release so internal state leaves reset cleanly
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end
      else
      begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // ==========================================================
   // operand shifters
   // one-place left shift, fill bit enters at the low end
   function automatic logic [7:0] shift_in_low(
      input logic [7:0] val,
      input logic fill
   );
      shift_in_low = {val[BRU_MSB-1:0], fill};
   endfunction

   // one-place right shift, fill bit enters at the high end
   function automatic logic [7:0] shift_in_high(
      input logic [7:0] val,
      input logic fill
   );
      shift_in_high = {fill, val[BRU_MSB:BRU_LSB+1]};
   endfunction

   // ==========================================================
   // rotate datapath
   // the operand is read as it stands at the taking edge; a write-back
   // launched by the previous op lands on that same edge, so a back-to-back
   // op on the same byte sees the old value and the decoder must space them
   logic [7:0] nxt_result;
   logic nxt_carry;
   logic to_work;

   // combinational result; carry kept unless a through-carry op
   always_comb
   begin
      nxt_result = mem_operand;
      nxt_carry = carry_ff;
      to_work = 1'b0;
      case (op)
         BRU_ROT_LEFT_TO_WORK:
         begin
            nxt_result = shift_in_low(mem_operand, mem_operand[BRU_MSB]); // [RULE_01]
            to_work = 1'b1;
         end
         BRU_ROT_LEFT_VIA_CY_INPLACE:
         begin
            nxt_result = shift_in_low(mem_operand, carry_ff); // [RULE_02]
            nxt_carry = mem_operand[BRU_MSB]; // [RULE_02]
         end
         BRU_ROT_LEFT_VIA_CY_TO_WORK:
         begin
            nxt_result = shift_in_low(mem_operand, carry_ff); // [RULE_03]
            nxt_carry = mem_operand[BRU_MSB]; // [RULE_03]
            to_work = 1'b1;
         end
         BRU_ROT_RIGHT_INPLACE:
         begin
            nxt_result = shift_in_high(mem_operand, mem_operand[BRU_LSB]); // [RULE_04]
         end
         BRU_ROT_RIGHT_TO_WORK:
         begin
            nxt_result = shift_in_high(mem_operand, mem_operand[BRU_LSB]); // [RULE_05]
            to_work = 1'b1;
         end
         BRU_ROT_RIGHT_VIA_CY_INPLACE:
         begin
            nxt_result = shift_in_high(mem_operand, carry_ff); // [RULE_06]
            nxt_carry = mem_operand[BRU_LSB]; // [RULE_06]
         end
         default:
         begin
            // unused codes do nothing visible
            nxt_result = mem_operand;
         end
      endcase
   end

   // ==========================================================
   // operation qualify
   // codes 6 and 7 are refused outright: no done, no write, no flag change
   logic valid_op;
   logic take_op;
   logic write_back;

   assign valid_op = (op <= BRU_ROT_RIGHT_VIA_CY_INPLACE);
   // an op is taken on any edge that sees start with a known code
   assign take_op = start && valid_op;
   // in-place ops return the result to the byte they read
   assign write_back = take_op && !to_work;

   // ==========================================================
   // result registers
   // working register: written only by to-work ops
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         work_reg_ff <= BRU_WORK_RST;
      else if (start && valid_op && to_work)
         work_reg_ff <= nxt_result; // [RULE_01] [RULE_03] [RULE_05]
   end

   // carry flag: non-carry ops leave it as it was
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         carry_ff <= BRU_CARRY_RST;
      else if (start && valid_op)
         carry_ff <= nxt_carry;
   end

   // ==========================================================
   // memory write path
   // write strobe: one-cycle pulse for in-place ops only
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         mem_we_ff <= 1'b0;
      else
         mem_we_ff <= write_back; // [RULE_02] [RULE_04] [RULE_06]
   end

   // write data: held between write-backs so a slow memory side may latch late
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         mem_wdata_ff <= 8'h00;
      else if (write_back)
         mem_wdata_ff <= nxt_result; // [RULE_02] [RULE_04] [RULE_06]
   end

   // completion pulse, one cycle after start
   always_ff @(posedge clk or negedge rst_n_ff)
   begin
      if (!rst_n_ff)
         done_ff <= 1'b0;
      else
         done_ff <= start && valid_op;
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n_ff);

   // per-op results, one cycle after the taking edge

   rol_work_a: assert property (start && op == BRU_ROT_LEFT_TO_WORK |=> // [RULE_01]
      work_reg_ff == {$past(mem_operand[6:0]), $past(mem_operand[7])} && !mem_we_ff
      && $stable(carry_ff)) else $error("left rotate to work wrong");
   rolc_mem_a: assert property (start && op == BRU_ROT_LEFT_VIA_CY_INPLACE |=> // [RULE_02]
      mem_we_ff && mem_wdata_ff == {$past(mem_operand[6:0]), $past(carry_ff)}
      && carry_ff == $past(mem_operand[7])) else $error("left via carry in place wrong");
   rolc_work_a: assert property (start && op == BRU_ROT_LEFT_VIA_CY_TO_WORK |=> // [RULE_03]
      work_reg_ff == {$past(mem_operand[6:0]), $past(carry_ff)} && !mem_we_ff
      && carry_ff == $past(mem_operand[7])) else $error("left via carry to work wrong");
   ror_mem_a: assert property (start && op == BRU_ROT_RIGHT_INPLACE |=> // [RULE_04]
      mem_we_ff && mem_wdata_ff == {$past(mem_operand[0]), $past(mem_operand[7:1])}
      && $stable(carry_ff) && $stable(work_reg_ff)) else $error("right in place wrong");
   ror_work_a: assert property (start && op == BRU_ROT_RIGHT_TO_WORK |=> // [RULE_05]
      work_reg_ff == {$past(mem_operand[0]), $past(mem_operand[7:1])} && !mem_we_ff
      && $stable(carry_ff)) else $error("right to work wrong");
   rorc_mem_a: assert property (start && op == BRU_ROT_RIGHT_VIA_CY_INPLACE |=> // [RULE_06]
      mem_we_ff && mem_wdata_ff == {$past(carry_ff), $past(mem_operand[7:1])}
      && carry_ff == $past(mem_operand[0])) else $error("right via carry wrong");
   idle_carry_a: assert property (!start |=> $stable(carry_ff) && !mem_we_ff)
      else $error("idle cycle changed state");

   // refused codes and idle cycles drop done and the write strobe; carry, working register and write data are left alone
   refused_op_a: assert property (start && !valid_op |=>
      !done_ff && !mem_we_ff && $stable(carry_ff) && $stable(work_reg_ff))
      else $error("refused code changed state");
   work_hold_a: assert property (!(take_op && to_work) |=> $stable(work_reg_ff))
      else $error("working register changed without a to-work op");
   wdata_hold_a: assert property (!write_back |=> $stable(mem_wdata_ff))
      else $error("write data changed without a write-back");

   // every taken op answers exactly one cycle later
   done_pulse_a: assert property (start && op <= BRU_ROT_RIGHT_VIA_CY_INPLACE |=> done_ff)
      else $error("taken op gave no done");
   we_done_a: assert property (mem_we_ff |-> done_ff)
      else $error("write strobe without done");

   // ==========================================================
   // cover points for the main scenarios
   c_left_cy: cover property (start && op == BRU_ROT_LEFT_VIA_CY_INPLACE && carry_ff);
   c_right_cy: cover property (start && op == BRU_ROT_RIGHT_VIA_CY_INPLACE ##1 start);
   c_work: cover property (start && op == BRU_ROT_RIGHT_TO_WORK);
   c_refused: cover property (start && !valid_op);
   c_left_work: cover property (start && op == BRU_ROT_LEFT_TO_WORK
      ##1 start && op == BRU_ROT_LEFT_VIA_CY_TO_WORK);
endmodule

// [bru_mem_model.sv]
// one data memory byte feeding the rotate unit
// assumes load comes from the bench only when no write-back is due
`timescale 1ns/1ps
module bru_mem_model
(
   input wire logic clk,
   input wire logic load,
   input wire logic [7:0] load_val,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata
);
   // =========================================
   // storage
   // write-back wins so a racing load cannot mask it
   always_ff @(posedge clk)
   begin
      if (we)
         rdata <= wdata;
      else if (load)
         rdata <= load_val;
   end
endmodule

// [bru_pkg.sv]
// byte rotate unit: shared constants and operation encoding
// assumes a decoder that issues one operation per start pulse
// ==========================================================
// How it works
// RULE_01: left rotate, bit 7 wraps to bit 0, result to working register only.
// RULE_02: left through carry, old carry into bit 0, bit 7 to carry, back to memory.
// RULE_03: left through carry to working register, carry from bit 7, memory kept.
// RULE_04: right rotate, bit 0 wraps to bit 7, back to memory, no flag.
// RULE_05: right rotate to working register, memory and flags unchanged.
// RULE_06: right through carry, old carry into bit 7, bit 0 to carry, to memory.
package bru_pkg;
   localparam int BRU_WIDTH = 8;
   localparam int BRU_MSB = 7;
   localparam int BRU_LSB = 0;
   localparam logic [7:0] BRU_WORK_RST = 8'h00;
   localparam logic BRU_CARRY_RST = 1'b0;

   // operation codes issued by the decoder
   typedef enum logic [2:0]
   {
      BRU_ROT_LEFT_TO_WORK = 3'h0,
      BRU_ROT_LEFT_VIA_CY_INPLACE = 3'h1,
      BRU_ROT_LEFT_VIA_CY_TO_WORK = 3'h2,
      BRU_ROT_RIGHT_INPLACE = 3'h3,
      BRU_ROT_RIGHT_TO_WORK = 3'h4,
      BRU_ROT_RIGHT_VIA_CY_INPLACE = 3'h5
   } bru_op_type;
endpackage

// [tb_top.sv]
// random and corner ops on the rotate unit, checked cycle by cycle
// assumes bru_pkg and bru_mem_model are compiled first
`timescale 1ns/1ps
module tb_top;
   import bru_pkg::*;
   // memory byte is loaded with zero through reset so it never reads unknown
   logic clk = 1'b0, resetn = 1'b0, start = 1'b0, load = 1'b1, cy, we, done, tk;
   logic [2:0] op_raw = 3'h0;
   logic [7:0] load_val = 8'h00, mem, work, wd, m_cur = 8'h00, nxt_m;
   logic [7:0] e_work = 8'h00, e_wd = 8'h00;
   logic e_cy = 1'b0, e_we = 1'b0, e_done = 1'b0;
   logic [8:0] r;
   int seed = 67112, miscompares = 0, cmp_count = 0, cycles = 0, i;
   bru_byte_rotate_unit uut (.clk(clk), .resetn(resetn), .start(start),
      .op(bru_op_type'(op_raw)), .mem_operand(mem), .work_reg_ff(work), .carry_ff(cy),
      .mem_wdata_ff(wd), .mem_we_ff(we), .done_ff(done));
   bru_mem_model mm (.clk(clk), .load(load), .load_val(load_val), .we(we), .wdata(wd),
      .rdata(mem));
   // =========================================
   // clock and hang guard
   initial
   begin
      forever #10 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 1000)
      begin
         miscompares++;
         finish_test();
      end
   end
   // expected {carry, byte}; plain rotates hand the old carry back
   function automatic logic [8:0] rot(input logic [2:0] o, input logic [7:0] v, input logic c);
      case (o)
         3'h0: rot = {c, v[6:0], v[7]};
         3'h1, 3'h2: rot = {v[7], v[6:0], c};
         3'h3, 3'h4: rot = {c, v[0], v[7:1]};
         default: rot = {v[0], c, v[7:1]};
      endcase
   endfunction
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      $display("compares %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // =========================================
   // first eight ops walk every code, 6 and 7 refused; then random
   initial
   begin
      repeat (16) @(posedge clk);
      @(negedge clk) resetn = 1'b1;
      repeat (3) @(posedge clk);
      for (i = 0; i < 600; i++)
      begin
         @(negedge clk);
         chk({3'h0, work}, {3'h0, e_work});
         chk({10'h000, cy}, {10'h000, e_cy});
         chk({9'h000, done, we}, {9'h000, e_done, e_we});
         chk({3'h0, wd}, {3'h0, e_wd});
         chk({3'h0, mem}, {3'h0, m_cur});
         r = 9'($random(seed));
         op_raw = (i < 8) ? i[2:0] : r[2:0];
         start = (i < 8) | r[3];
         load = !e_we && (i < 8 || r[8]);
         load_val = (i < 8) ? 8'h81 : 8'($random(seed));
         tk = start && op_raw < 3'h6;
         nxt_m = e_we ? e_wd : (load ? load_val : m_cur);
         r = rot(op_raw, m_cur, e_cy);
         e_done = tk;
         e_we = tk && (op_raw == 3'h1 || op_raw == 3'h3 || op_raw == 3'h5);
         if (tk)
            e_cy = r[8];
         if (tk && (op_raw == 3'h0 || op_raw == 3'h2 || op_raw == 3'h4))
            e_work = r[7:0];
         if (e_we)
            e_wd = r[7:0];
         m_cur = nxt_m;
      end
      finish_test();
   end
endmodule
